// ---- rtl/vic_top.sv ----
// Vectored interrupt controller with an Avalon-MM register port and a core handshake.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`default_nettype none

module vic_top (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [vic_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [vic_pkg::DATA_W-1:0] avs_writedata,
   output logic [vic_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [vic_pkg::NUM_SRC-1:0] src_flag_set,
   input wire logic [1:0] ext_pin,
   input wire logic instr_done,
   input wire logic instr_multi,
   input wire logic ret_done,
   output logic irq_req,
   output logic [vic_pkg::SRC_W-1:0] irq_source,
   output logic [vic_pkg::VEC_W-1:0] irq_vector,
   output logic vec_call,
   output logic call_busy,
   output logic irq
);
   // Register state.
   logic [vic_pkg::NUM_SRC-1:0] pend, next_pend;
   logic [vic_pkg::SRC_PER_EN:0] en_a, next_en_a;
   logic [vic_pkg::SRC_PER_EN-1:0] en_b, next_en_b;
   logic [vic_pkg::NUM_SRC-1:0] prio, next_prio;
   logic [vic_pkg::EVT_W-1:0] evt, next_evt;
   logic [vic_pkg::EVT_W-1:0] evt_mask, next_evt_mask;
   logic [vic_pkg::DATA_W-1:0] next_readdata;
   logic next_waitrequest, next_irq;

   // Core sequencing state.
   vic_pkg::ctl_e ctl, next_ctl;
   logic [vic_pkg::CNT_W-1:0] cnt, next_cnt;
   logic svc_hi, next_svc_hi, svc_lo, next_svc_lo;
   logic posted, next_posted, posted_hi, next_posted_hi;
   logic [vic_pkg::SRC_W-1:0] posted_idx, next_posted_idx;
   logic race, next_race, hold_one, next_hold_one;
   logic [1:0] ext_prev, next_ext_prev;
   logic next_irq_req, next_vec_call, next_call_busy;
   logic [vic_pkg::SRC_W-1:0] next_irq_source;
   logic [vic_pkg::VEC_W-1:0] next_irq_vector;

   // Combinational helpers.
   logic [1:0] ext_s;
   logic gie;
   logic [vic_pkg::NUM_SRC-1:0] en_vec, live;
   logic valid_hi, valid_lo, hi_ok, lo_ok, live_any, take, drop;
   logic [vic_pkg::SRC_W-1:0] idx_hi, idx_lo;
   logic bus_wr, bus_rd, en_cleared;
   logic [vic_pkg::NUM_SRC-1:0] ext_set;

   vic_sync #(.W(2)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .d(ext_pin),
      .q(ext_s)
   );

   vic_arbiter u_arb (
      .live(live),
      .prio_hi(prio),
      .valid_hi(valid_hi),
      .idx_hi(idx_hi),
      .valid_lo(valid_lo),
      .idx_lo(idx_lo)
   );

   always_comb
   begin
      gie = en_a[vic_pkg::GIE_BIT];
      en_vec = {en_b, en_a[vic_pkg::SRC_PER_EN-1:0]};
      // Flags stay pending while disabled; they simply drop out of arbitration here.
      live = pend & en_vec & {vic_pkg::NUM_SRC{gie}};
      // A high-level routine blocks everything, a low-level one blocks only low requests.
      hi_ok = valid_hi && !svc_hi;
      lo_ok = valid_lo && !svc_hi && !svc_lo;
      live_any = hi_ok || lo_ok;
      bus_wr = avs_write && !avs_waitrequest;
      bus_rd = avs_read && !avs_waitrequest;
      en_cleared = bus_wr &&
         (((avs_address == vic_pkg::OFS_EN_A) && |(en_a & ~avs_writedata[vic_pkg::SRC_PER_EN:0])) ||
          ((avs_address == vic_pkg::OFS_EN_B) && |(en_b & ~avs_writedata[vic_pkg::SRC_PER_EN-1:0])));
      // The request sampled before an enable was cleared survives a single-cycle follower only.
      take = (ctl == vic_pkg::ST_RUN) && instr_done && !hold_one && posted &&
         (live_any || (race && !instr_multi));
      drop = (ctl == vic_pkg::ST_RUN) && instr_done && !hold_one && posted &&
         !live_any && race && instr_multi;
      ext_set = '0;
      ext_set[vic_pkg::EXT0_SRC] = ext_s[0] && !ext_prev[0];
      ext_set[vic_pkg::EXT1_SRC] = ext_s[1] && !ext_prev[1];
   end

   // Register file, pending flags, bus answer and interrupt output.
   always_comb
   begin
      next_pend = pend;
      next_en_a = en_a;
      next_en_b = en_b;
      next_prio = prio;
      next_evt = evt;
      next_evt_mask = evt_mask;
      next_ext_prev = ext_s;
      next_readdata = avs_readdata;
      // One wait cycle, then the request is taken on the edge where waitrequest is low.
      next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
      if ((avs_read || avs_write) && avs_waitrequest)
      begin
         next_readdata = '0;
         unique case (avs_address)
            vic_pkg::OFS_PEND: next_readdata = vic_pkg::DATA_W'(pend);
            vic_pkg::OFS_EN_A: next_readdata = vic_pkg::DATA_W'(en_a);
            vic_pkg::OFS_EN_B: next_readdata = vic_pkg::DATA_W'(en_b);
            vic_pkg::OFS_PRIO: next_readdata = vic_pkg::DATA_W'(prio);
            vic_pkg::OFS_STATUS:
            begin
               next_readdata[vic_pkg::ST_SVC_LO_BIT] = svc_lo;
               next_readdata[vic_pkg::ST_SVC_HI_BIT] = svc_hi;
               next_readdata[vic_pkg::ST_RACE_BIT] = race;
               next_readdata[vic_pkg::ST_HOLD_BIT] = hold_one;
               next_readdata[vic_pkg::ST_SRC_LSB +: vic_pkg::SRC_W] = posted_idx;
            end
            vic_pkg::OFS_EVT: next_readdata = vic_pkg::DATA_W'(evt);
            vic_pkg::OFS_EVT_MASK: next_readdata = vic_pkg::DATA_W'(evt_mask);
            default: next_readdata = '0;
         endcase
         if (avs_write)
         begin
            next_readdata = '0;
         end
      end
      if (bus_wr)
      begin
         unique case (avs_address)
            vic_pkg::OFS_PEND: next_pend = next_pend & ~avs_writedata[vic_pkg::NUM_SRC-1:0];
            vic_pkg::OFS_EN_A: next_en_a = avs_writedata[vic_pkg::SRC_PER_EN:0];
            vic_pkg::OFS_EN_B: next_en_b = avs_writedata[vic_pkg::SRC_PER_EN-1:0];
            vic_pkg::OFS_PRIO: next_prio = avs_writedata[vic_pkg::NUM_SRC-1:0];
            vic_pkg::OFS_EVT: next_evt = next_evt & ~avs_writedata[vic_pkg::EVT_W-1:0];
            vic_pkg::OFS_EVT_MASK: next_evt_mask = avs_writedata[vic_pkg::EVT_W-1:0];
            default: next_pend = next_pend;
         endcase
      end
      if (take)
      begin
         next_pend[posted_idx] = next_pend[posted_idx] & ~vic_pkg::HW_CLEAR_MASK[posted_idx];
      end
      // Sets are applied last so a flag raised in its clearing cycle is kept.
      next_pend = next_pend | src_flag_set | ext_set;
      if (bus_wr && (avs_address == vic_pkg::OFS_PEND_SET))
      begin
         next_pend = next_pend | avs_writedata[vic_pkg::NUM_SRC-1:0];
      end
      next_evt[vic_pkg::EVT_TAKEN] = next_evt[vic_pkg::EVT_TAKEN] | take;
      next_evt[vic_pkg::EVT_RETURN] = next_evt[vic_pkg::EVT_RETURN] | ret_done;
      next_evt[vic_pkg::EVT_DROP] = next_evt[vic_pkg::EVT_DROP] | drop;
      next_irq = |(evt & evt_mask);
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pend <= '0;
         en_a <= '0;
         en_b <= '0;
         prio <= '0;
         evt <= '0;
         evt_mask <= '0;
         ext_prev <= '0;
         avs_readdata <= '0;
         avs_waitrequest <= 1'b1;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         pend <= next_pend;
         en_a <= next_en_a;
         en_b <= next_en_b;
         prio <= next_prio;
         evt <= next_evt;
         evt_mask <= next_evt_mask;
         ext_prev <= next_ext_prev;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
         irq <= next_irq;
      end
   end

   // Core handshake: sampling, vectoring, service levels and return handling.
   always_comb
   begin
      next_ctl = ctl;
      next_cnt = cnt;
      next_svc_hi = svc_hi;
      next_svc_lo = svc_lo;
      next_hold_one = hold_one;
      next_race = race;
      next_vec_call = 1'b0;
      next_irq_vector = irq_vector;
      next_irq_source = irq_source;
      // Sampled every cycle; this register is the one detect cycle before the call.
      next_posted = live_any;
      next_posted_hi = hi_ok;
      next_posted_idx = hi_ok ? idx_hi : idx_lo;
      if (en_cleared && posted)
      begin
         // Keep the stale request alive until the next instruction boundary.
         next_race = 1'b1;
         next_posted = 1'b1;
         next_posted_hi = posted_hi;
         next_posted_idx = posted_idx;
      end
      else if (race && !instr_done)
      begin
         next_posted = posted;
         next_posted_hi = posted_hi;
         next_posted_idx = posted_idx;
      end
      if (instr_done)
      begin
         next_race = 1'b0;
         // The instruction after a return always runs before any new call.
         next_hold_one = 1'b0;
      end
      if (ret_done)
      begin
         next_hold_one = 1'b1;
         if (svc_hi)
         begin
            next_svc_hi = 1'b0;
         end
         else
         begin
            next_svc_lo = 1'b0;
         end
      end
      unique case (ctl)
         vic_pkg::ST_RUN:
         begin
            if (take)
            begin
               next_ctl = vic_pkg::ST_CALL;
               next_cnt = vic_pkg::CALL_LAST;
               next_vec_call = 1'b1;
               next_irq_source = posted_idx;
               next_irq_vector = vic_pkg::vec_of(posted_idx);
               next_race = 1'b0;
               next_posted = 1'b0;
               if (posted_hi)
               begin
                  next_svc_hi = 1'b1;
               end
               else
               begin
                  next_svc_lo = 1'b1;
               end
            end
         end
         vic_pkg::ST_CALL:
         begin
            next_posted = 1'b0;
            next_cnt = cnt - 1'b1;
            if (cnt == '0)
            begin
               next_ctl = vic_pkg::ST_RUN;
            end
         end
      endcase
      next_call_busy = (next_ctl == vic_pkg::ST_CALL);
      next_irq_req = next_posted && (next_ctl == vic_pkg::ST_RUN) && !next_hold_one;
      if (next_irq_req)
      begin
         next_irq_source = next_posted_idx;
         next_irq_vector = vic_pkg::vec_of(next_posted_idx);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl <= vic_pkg::ST_RUN;
         cnt <= '0;
         svc_hi <= 1'b0;
         svc_lo <= 1'b0;
         posted <= 1'b0;
         posted_hi <= 1'b0;
         posted_idx <= '0;
         race <= 1'b0;
         hold_one <= 1'b0;
         irq_req <= 1'b0;
         irq_source <= '0;
         irq_vector <= vic_pkg::RESET_VECTOR;
         vec_call <= 1'b0;
         call_busy <= 1'b0;
      end
      else if (ce)
      begin
         ctl <= next_ctl;
         cnt <= next_cnt;
         svc_hi <= next_svc_hi;
         svc_lo <= next_svc_lo;
         posted <= next_posted;
         posted_hi <= next_posted_hi;
         posted_idx <= next_posted_idx;
         race <= next_race;
         hold_one <= next_hold_one;
         irq_req <= next_irq_req;
         irq_source <= next_irq_source;
         irq_vector <= next_irq_vector;
         vec_call <= next_vec_call;
         call_busy <= next_call_busy;
      end
   end

   // Checks. Assertion attempts are dropped while the clock enable is low; the covers ignore it.
   chk_global_gate: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      !gie && !race |=> !posted)
      else $error("request posted while global enable low");
   chk_call_length: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      vec_call |-> call_busy [*5] ##1 !call_busy)
      else $error("call phase not five cycles");
   chk_vector_map: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      vec_call |-> irq_vector == vic_pkg::vec_of(irq_source))
      else $error("vector does not match source");
   chk_high_no_preempt: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      svc_hi && !ret_done |=> !vec_call)
      else $error("high-level routine preempted");
   chk_return_hold: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      ret_done |=> !vec_call ##1 !vec_call)
      else $error("call made right after return");
   chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      |src_flag_set |=> (pend & $past(src_flag_set)) == $past(src_flag_set))
      else $error("pending flag not set");
   chk_race_multi: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      drop |=> !vec_call && !call_busy)
      else $error("stale request taken before multi-cycle instruction");
   chk_race_single: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      ctl == vic_pkg::ST_RUN && instr_done && !instr_multi && race && posted && !hold_one |=> vec_call)
      else $error("stale request lost before single-cycle instruction");
   chk_bus_wait: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   chk_winner_vec: assert property (@(posedge clk_sys) disable iff (!rstn || !ce)
      irq_req |-> irq_vector == vic_pkg::vec_of(irq_source) && !call_busy)
      else $error("presented vector not the winner's");

   cov_take: cover property (@(posedge clk_sys) disable iff (!rstn) vec_call);
   cov_preempt: cover property (@(posedge clk_sys) disable iff (!rstn) svc_lo && vec_call && svc_hi);
   cov_reentry: cover property (@(posedge clk_sys) disable iff (!rstn) ret_done ##[1:20] vec_call);
   cov_drop: cover property (@(posedge clk_sys) disable iff (!rstn) drop);
endmodule

`default_nettype wire

// ---- rtl/vic_pkg.sv ----
// Constants, encodings and helper functions shared by the interrupt controller files.
// Behaviour
// - Fourteen sources, each set to low or high priority.
// - A valid source condition sets that source's pending flag.
// - Pending flags set even when disabled; disabled flags are ignored.
// - Enabled pending source raises a request; call happens at instruction end.
// - Return resumes the instruction that would have run next.
// - Per-source enables count only while the global enable is one.
// - Global enable zero blocks every request.
// - Request posted during enable clear, single-cycle follower: may be taken.
// - Request posted during enable clear, multi-cycle follower: not taken.
// - Some flags cleared by hardware on vectoring; others by software.
// - Flag still set after return: new request, one instruction runs first.
// - High preempts low, high never preempted, fixed order breaks ties.
// - Requests sampled every cycle; one detect cycle then five call cycles.
// - Fixed vector per source; reset zero, first source at three, the rest eight apart.
// - Equal or higher routine in service makes new requests wait.
`default_nettype none

package vic_pkg;
   localparam int NUM_SRC = 14;
   localparam int SRC_W = 4;
   localparam int VEC_W = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int SRC_PER_EN = 7;
   localparam int EVT_W = 3;

   localparam logic [ADDR_W-1:0] OFS_PEND = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PEND_SET = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EN_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EN_B = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_EVT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h1c;

   localparam int GIE_BIT = 7;
   localparam int ST_SVC_LO_BIT = 0;
   localparam int ST_SVC_HI_BIT = 1;
   localparam int ST_RACE_BIT = 2;
   localparam int ST_HOLD_BIT = 3;
   localparam int ST_SRC_LSB = 16;

   localparam int EVT_TAKEN = 0;
   localparam int EVT_RETURN = 1;
   localparam int EVT_DROP = 2;

   localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 14'h000f;
   localparam int EXT0_SRC = 0;
   localparam int EXT1_SRC = 2;

   localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
   localparam logic [VEC_W-1:0] FIRST_VECTOR = 16'h0003;
   localparam logic [VEC_W-1:0] VECTOR_STRIDE = 16'h0008;

   localparam int CALL_CYCLES = 5;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CALL_LAST = CNT_W'(CALL_CYCLES - 1);

   typedef enum logic {ST_RUN, ST_CALL} ctl_e;

   function automatic logic [SRC_W-1:0] first_index(input logic [NUM_SRC-1:0] v);
      logic [SRC_W-1:0] r;
      r = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = SRC_W'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [VEC_W-1:0] vec_of(input logic [SRC_W-1:0] idx);
      logic [VEC_W-1:0] r;
      r = FIRST_VECTOR + VEC_W'(VECTOR_STRIDE * VEC_W'(idx));
      return r;
   endfunction
endpackage

`default_nettype wire

// ---- rtl/vic_sync.sv ----
// Two-flop synchroniser for the external interrupt pins.
`default_nettype none

module vic_sync #(
   parameter int W = 2
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

`default_nettype wire

// ---- rtl/vic_arbiter.sv ----
// Priority resolver: best high-level and best low-level candidate by fixed order.
`default_nettype none

module vic_arbiter (
   input wire logic [vic_pkg::NUM_SRC-1:0] live,
   input wire logic [vic_pkg::NUM_SRC-1:0] prio_hi,
   output logic valid_hi,
   output logic [vic_pkg::SRC_W-1:0] idx_hi,
   output logic valid_lo,
   output logic [vic_pkg::SRC_W-1:0] idx_lo
);
   logic [vic_pkg::NUM_SRC-1:0] cand_hi;
   logic [vic_pkg::NUM_SRC-1:0] cand_lo;

   always_comb
   begin
      cand_hi = live & prio_hi;
      cand_lo = live & ~prio_hi;
      valid_hi = |cand_hi;
      valid_lo = |cand_lo;
      // Lower index wins among equal levels.
      idx_hi = vic_pkg::first_index(cand_hi);
      idx_lo = vic_pkg::first_index(cand_lo);
   end
endmodule

`default_nettype wire

// ---- tb/core_model.sv ----
// Behavioural processor core that paces instruction boundaries and returns from handlers.
`default_nettype none

module core_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic run,
   input wire logic multi,
   input wire logic ret_cmd,
   input wire logic call_busy,
   output logic instr_done,
   output logic instr_multi,
   output logic ret_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic phase;

   // While run is high, an instruction ends every other cycle, and the core is stalled while a call is under way.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         phase <= 1'b0;
         instr_done <= 1'b0;
         instr_multi <= 1'b0;
         ret_done <= 1'b0;
      end
      else
      begin
         phase <= ~phase;
         instr_done <= run && phase && !call_busy && !ret_cmd;
         // The qualifier means nothing between boundaries, so it keeps changing there.
         instr_multi <= (run && phase) ? multi : ~instr_multi;
         ret_done <= ret_cmd;
      end
   end
endmodule

`default_nettype wire

// ---- tb/vectored_interrupt_controller_tb.sv ----
// Self-checking bench for the vectored interrupt controller.
`default_nettype none

module vectored_interrupt_controller_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [13:0] src_flag_set = '0;
   logic [1:0] ext_pin = '0;
   logic instr_done, instr_multi, ret_done, irq_req, vec_call, call_busy, irq;
   logic [3:0] irq_source;
   logic [15:0] irq_vector;
   logic run = 1'b0;
   logic multi = 1'b0;
   logic ret_cmd = 1'b0;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int seed = 52618;

   always #5 clk_sys = ~clk_sys;

   vic_top dut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .src_flag_set(src_flag_set), .ext_pin(ext_pin),
      .instr_done(instr_done), .instr_multi(instr_multi), .ret_done(ret_done), .irq_req(irq_req),
      .irq_source(irq_source), .irq_vector(irq_vector), .vec_call(vec_call), .call_busy(call_busy), .irq(irq));

   core_model core (.clk_sys(clk_sys), .rstn(rstn), .run(run), .multi(multi), .ret_cmd(ret_cmd),
      .call_busy(call_busy), .instr_done(instr_done), .instr_multi(instr_multi), .ret_done(ret_done));

   function automatic logic [15:0] exp_vec(input int i);
      return vic_pkg::FIRST_VECTOR + 16'(i) * vic_pkg::VECTOR_STRIDE;
   endfunction

   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   // The request stays put until waitrequest is sampled low; the answer is taken at that edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Only the bench timeout may end this wait.
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      cmp_word(what, e, q);
   endtask

   task automatic wait_for(input bit call, input int lim, output bit seen);
      seen = 1'b0;
      repeat (lim)
      begin
         @(posedge clk_sys);
         if ((call ? vec_call : irq_req) === 1'b1)
         begin
            seen = 1'b1;
            break;
         end
      end
   endtask

   task automatic take(input string what);
      bit seen;
      int n;
      run <= 1'b1;
      wait_for(1'b1, 20, seen);
      run <= 1'b0;
      cmp_bit(what, 1'b1, seen);
      n = 1;
      @(posedge clk_sys);
      while (call_busy === 1'b1 && n < 9)
      begin
         n++;
         @(posedge clk_sys);
      end
      cmp_word("call cycles", 32'd5, 32'(n));
   endtask

   task automatic ret();
      @(posedge clk_sys);
      ret_cmd <= 1'b1;
      @(posedge clk_sys);
      ret_cmd <= 1'b0;
   endtask

   task automatic expect_post(input string what, input int src);
      bit seen;
      // After a return the core must finish one instruction before a request is shown.
      run <= 1'b1;
      wait_for(1'b0, 10, seen);
      cmp_bit(what, 1'b1, seen);
      cmp_word("source", 32'(src), 32'(irq_source));
      cmp_word("vector", 32'(exp_vec(src)), 32'(irq_vector));
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         summarize();
      end
   end

   initial
   begin
      logic [13:0] acc;
      logic [13:0] m;
      bit seen;
      int n;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int a = 0; a <= 32; a += 4)
      begin
         rd_chk("reset read", 8'(a), 32'h0);
      end
      ext_pin <= 2'b11;
      repeat (4) @(posedge clk_sys);
      rd_chk("pin flags", vic_pkg::OFS_PEND, 32'h5);
      wr(vic_pkg::OFS_PEND, 32'h3fff);
      wr(vic_pkg::OFS_EN_A, 32'h7f);
      wr(vic_pkg::OFS_EN_B, 32'h7f);
      acc = '0;
      repeat (16)
      begin
         m = 14'($random(seed));
         acc |= m;
         @(posedge clk_sys);
         src_flag_set <= m;
         @(posedge clk_sys);
         src_flag_set <= '0;
         rd_chk("pending", vic_pkg::OFS_PEND, 32'(acc));
         cmp_bit("no request", 1'b0, irq_req);
      end
      wr(vic_pkg::OFS_PEND, 32'h3fff);
      wr(vic_pkg::OFS_EN_A, 32'h0);
      wr(vic_pkg::OFS_EN_B, 32'h0);
      for (int i = 0; i < 14; i++)
      begin
         wr(vic_pkg::OFS_PEND_SET, 32'(1) << i);
         wr(vic_pkg::OFS_EN_A, (i < 7) ? (32'h80 | (32'(1) << i)) : 32'h80);
         wr(vic_pkg::OFS_EN_B, (i < 7) ? 32'h0 : (32'(1) << (i - 7)));
         expect_post("posted", i);
         take("call");
         rd_chk("after call", vic_pkg::OFS_PEND, (i < 4) ? 32'h0 : (32'(1) << i));
         wr(vic_pkg::OFS_PEND, 32'h3fff);
         wr(vic_pkg::OFS_EN_A, 32'h0);
         wr(vic_pkg::OFS_EN_B, 32'h0);
         ret();
      end
      wr(vic_pkg::OFS_PEND_SET, 32'h20);
      wr(vic_pkg::OFS_EN_A, 32'ha0);
      take("entry");
      wait_for(1'b0, 12, seen);
      cmp_bit("held in service", 1'b0, seen);
      rd_chk("status in service", vic_pkg::OFS_STATUS, 32'h0005_0001);
      ret();
      run <= 1'b1;
      n = 0;
      repeat (20)
      begin
         @(posedge clk_sys);
         if (vec_call === 1'b1)
            break;
         n += (instr_done === 1'b1);
      end
      run <= 1'b0;
      cmp_word("instructions before re-entry", 32'd2, 32'(n));
      wr(vic_pkg::OFS_PEND, 32'h3fff);
      ret();
      wr(vic_pkg::OFS_PRIO, 32'h202);
      wr(vic_pkg::OFS_EN_A, 32'hb2);
      wr(vic_pkg::OFS_EN_B, 32'h4);
      wr(vic_pkg::OFS_PEND_SET, 32'h30);
      expect_post("tie", 4);
      take("low call");
      wr(vic_pkg::OFS_PEND, 32'h30);
      wr(vic_pkg::OFS_PEND_SET, 32'h200);
      expect_post("preempt", 9);
      take("high call");
      wr(vic_pkg::OFS_PEND_SET, 32'h2);
      wait_for(1'b0, 12, seen);
      cmp_bit("high not preempted", 1'b0, seen);
      wr(vic_pkg::OFS_PEND, 32'h200);
      ret();
      expect_post("after high return", 1);
      take("second high");
      ret();
      ret();
      wr(vic_pkg::OFS_PRIO, 32'h0);
      wr(vic_pkg::OFS_EVT, 32'h7);
      wr(vic_pkg::OFS_EVT_MASK, 32'h5);
      for (int k = 0; k < 2; k++)
      begin
         // One instruction with nothing pending clears the hold left by the last return.
         run <= 1'b1;
         repeat (4) @(posedge clk_sys);
         run <= 1'b0;
         rd_chk("status idle", vic_pkg::OFS_STATUS, 32'h0);
         wr(vic_pkg::OFS_PEND_SET, 32'h40);
         wr(vic_pkg::OFS_EN_A, 32'hc0);
         wait_for(1'b0, 10, seen);
         cmp_bit("race posted", 1'b1, seen);
         wr(vic_pkg::OFS_EN_A, 32'h0);
         multi <= k[0];
         run <= 1'b1;
         wait_for(1'b1, 12, seen);
         run <= 1'b0;
         cmp_bit("race taken", !k[0], seen);
         rd_chk("enable in handler", vic_pkg::OFS_EN_A, 32'h0);
         rd_chk("events", vic_pkg::OFS_EVT, (k == 1) ? 32'h6 : 32'h1);
         cmp_bit("irq raised", 1'b1, irq);
         wr(vic_pkg::OFS_PEND, 32'h3fff);
         if (k == 0)
            ret();
         wr(vic_pkg::OFS_EVT, 32'h5);
         repeat (2) @(posedge clk_sys);
         cmp_bit("irq cleared", 1'b0, irq);
      end
      // The return event stays set but is masked, so the interrupt line stays low.
      rd_chk("masked event", vic_pkg::OFS_EVT, 32'h2);
      summarize();
   end
endmodule

`default_nettype wire
